// ==== hdl/pgdec_top.sv ====
// Purpose: forms the register address and holds the shared page selection register
// Assumes: host strobes and address arrive asynchronously; one write strobe level per access
// Notes: address and data pass two flops, so a strobe must stand at least three cycles
`timescale 1ns/100ps
`include "pgdec_defines.svh"
// How it works
// - page selection register answers at addresses 00h,08h,...,38h
// - reset leaves page selection at 80h: page mode, page zero
// - in page mode page number forms address bits 5 to 3
// - in page mode low bits come from pins or latch per interface
// - out of page mode whole address comes from the latch
// - bits 6 to 3 read zero; flag and page number read and write
module pgdec_top (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [2:0] addr_pins,
  input wire logic [5:0] addr_latch,
  input wire logic if_is_latch,
  input wire logic wr_strobe,
  input wire logic [7:0] wr_data,
  output logic [5:0] reg_addr,
  output logic page_sel_hit,
  output logic use_page_flag,
  output logic [2:0] page_number,
  output logic [7:0] page_sel_rdata
);
  // ******************************
  // input synchronisers
  // ******************************
  logic [2:0] pins_s;
  logic [5:0] latch_s;
  logic ifl_s;
  logic wr_s;
  logic [7:0] wd_s;
  logic wr_prev_reg;
  pgdec_sync #(.W(19)) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .d({addr_pins, addr_latch, if_is_latch, wr_strobe, wr_data}),
    .q({pins_s, latch_s, ifl_s, wr_s, wd_s})
  );

  // ******************************
  // address composition
  // ******************************
  logic [7:0] page_sel_reg;
  logic [7:0] page_sel_next;
  pgdec_pkg::pgdec_if_t if_sel;
  wire use_page = page_sel_reg[`PGDEC_USE_PAGE_BIT];
  wire [2:0] page = page_sel_reg[`PGDEC_PAGE_MSB:`PGDEC_PAGE_LSB];
  wire [2:0] low_bits = (if_sel == pgdec_pkg::PGDEC_IF_LATCH) ? latch_s[2:0] : pins_s;
  wire [5:0] addr_next = use_page ? {page, low_bits} : latch_s;
  wire hit_next = (addr_next[2:0] == `PGDEC_PAGE_SEL_OFFS);
  wire wr_edge = wr_s & ~wr_prev_reg;
  assign if_sel = ifl_s ? pgdec_pkg::PGDEC_IF_LATCH : pgdec_pkg::PGDEC_IF_PINS;
  assign page_sel_next = (wr_edge && hit_next) ? (wd_s & `PGDEC_PAGE_SEL_MASK) : page_sel_reg;

  // ******************************
  // registers
  // ******************************
  // the write uses the address composed with the old page, as the host addressed it
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      page_sel_reg <= `PGDEC_PAGE_SEL_RESET;
      wr_prev_reg <= 1'b0;
    end
    else
    begin
      page_sel_reg <= page_sel_next;
      wr_prev_reg <= wr_s;
    end
  end

  // ******************************
  // address outputs
  // ******************************
  // reset shows address 00h, the page register itself, so the hit flag starts high
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      reg_addr <= `PGDEC_ADDR_RESET;
      page_sel_hit <= `PGDEC_HIT_RESET;
    end
    else
    begin
      reg_addr <= addr_next;
      page_sel_hit <= hit_next;
    end
  end

  // ******************************
  // page register view
  // ******************************
  // view follows the next value, so a write shows one cycle before the new address
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      use_page_flag <= `PGDEC_FLAG_RESET;
      page_number <= `PGDEC_PAGE_RESET;
      page_sel_rdata <= `PGDEC_PAGE_SEL_RESET;
    end
    else
    begin
      use_page_flag <= page_sel_next[`PGDEC_USE_PAGE_BIT];
      page_number <= page_sel_next[`PGDEC_PAGE_MSB:`PGDEC_PAGE_LSB];
      page_sel_rdata <= page_sel_next & `PGDEC_PAGE_SEL_MASK;
    end
  end

  // ******************************
  // checks
  // ******************************
  property p_reset_value;
    @(posedge mclk) !nrst |=> page_sel_rdata == 8'h80;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("page select reset value wrong");

  property p_reserved_zero;
    @(posedge mclk) disable iff (!nrst) page_sel_rdata[6:3] == 4'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_page_mode_high;
    @(posedge mclk) disable iff (!nrst) use_page |=> reg_addr[5:3] == $past(page);
  endproperty
  a_page_mode_high: assert property (p_page_mode_high) else $error("page bits not used");

  property p_page_mode_low;
    @(posedge mclk) disable iff (!nrst) use_page && !ifl_s |=> reg_addr[2:0] == $past(pins_s);
  endproperty
  a_page_mode_low: assert property (p_page_mode_low) else $error("pin bits not used");

  property p_latch_mode;
    @(posedge mclk) disable iff (!nrst) !use_page |=> reg_addr == $past(latch_s);
  endproperty
  a_latch_mode: assert property (p_latch_mode) else $error("latch address not used");

  property p_hit;
    @(posedge mclk) disable iff (!nrst) page_sel_hit == (reg_addr[2:0] == 3'h0);
  endproperty
  a_hit: assert property (p_hit) else $error("page register decode wrong");

  sequence s_write_hit;
    wr_edge && hit_next;
  endsequence
  property p_write_takes;
    @(posedge mclk) disable iff (!nrst) s_write_hit |=> page_sel_rdata == ($past(wd_s) & 8'h87);
  endproperty
  a_write_takes: assert property (p_write_takes) else $error("page register write lost");

  property p_no_stray_write;
    @(posedge mclk) disable iff (!nrst) !(wr_edge && hit_next) |=> $stable(page_sel_reg);
  endproperty
  a_no_stray_write: assert property (p_no_stray_write) else $error("page register changed");

  // ******************************
  // output and reset checks
  // ******************************
  property p_reset_view;
    @(posedge mclk) !nrst |=> use_page_flag && page_number == 3'h0;
  endproperty
  a_reset_view: assert property (p_reset_view) else $error("page view reset value wrong");

  property p_reset_addr;
    @(posedge mclk) !nrst |=> reg_addr == 6'h00 && page_sel_hit;
  endproperty
  a_reset_addr: assert property (p_reset_addr) else $error("address reset value wrong");

  property p_flag_view;
    @(posedge mclk) disable iff (!nrst) use_page_flag == use_page;
  endproperty
  a_flag_view: assert property (p_flag_view) else $error("page flag output wrong");

  property p_page_view;
    @(posedge mclk) disable iff (!nrst) page_number == page;
  endproperty
  a_page_view: assert property (p_page_view) else $error("page number output wrong");

  // ******************************
  // address checks
  // ******************************
  property p_page_mode_latch;
    @(posedge mclk) disable iff (!nrst) use_page && ifl_s |=> reg_addr[2:0] == $past(latch_s[2:0]);
  endproperty
  a_page_mode_latch: assert property (p_page_mode_latch) else $error("latch low bits not used");

  property p_latch_mode_hit;
    @(posedge mclk) disable iff (!nrst) !use_page |=> page_sel_hit == ($past(latch_s[2:0]) == 3'h0);
  endproperty
  a_latch_mode_hit: assert property (p_latch_mode_hit) else $error("latch mode decode wrong");

  property p_every_page;
    @(posedge mclk) disable iff (!nrst) use_page && low_bits == 3'h0 |=> page_sel_hit && reg_addr[5:3] == $past(page);
  endproperty
  a_every_page: assert property (p_every_page) else $error("page register missing in page");

  // ******************************
  // write checks
  // ******************************
  sequence s_write_refused;
    wr_edge && !hit_next;
  endsequence
  property p_refused_write;
    @(posedge mclk) disable iff (!nrst) s_write_refused |=> $stable(page_sel_rdata);
  endproperty
  a_refused_write: assert property (p_refused_write) else $error("write to other address taken");

  sequence s_write_sets_page;
    s_write_hit ##1 use_page;
  endsequence
  property p_new_page_used;
    @(posedge mclk) disable iff (!nrst) s_write_sets_page |=> reg_addr[5:3] == $past(wd_s[2:0], 2);
  endproperty
  a_new_page_used: assert property (p_new_page_used) else $error("written page not used");

  sequence s_write_clears_page;
    s_write_hit ##1 !use_page;
  endsequence
  property p_latch_takes_over;
    @(posedge mclk) disable iff (!nrst) s_write_clears_page |=> reg_addr == $past(latch_s);
  endproperty
  a_latch_takes_over: assert property (p_latch_takes_over) else $error("latch not used after clear");
endmodule : pgdec_top

// ==== hdl/pgdec_defines.svh ====
// Purpose: constants of the paged register address decoder
// Assumes: 8-bit host data, 6-bit register address
// Notes: offsets are 3-bit low address bits, matched in every 8-location page of the 64-location map
`ifndef PGDEC_DEFINES_SVH
`define PGDEC_DEFINES_SVH
`define PGDEC_PAGE_SEL_OFFS 3'h0
`define PGDEC_PAGE_SEL_RESET 8'h80
`define PGDEC_USE_PAGE_BIT 7
`define PGDEC_PAGE_MSB 2
`define PGDEC_PAGE_LSB 0
`define PGDEC_PAGE_SEL_MASK 8'h87
`define PGDEC_ADDR_RESET 6'h00
`define PGDEC_HIT_RESET 1'b1
`define PGDEC_FLAG_RESET 1'b1
`define PGDEC_PAGE_RESET 3'h0
`endif

// ==== hdl/pgdec_pkg.sv ====
// Purpose: shared types of the paged register address decoder
// Assumes: nothing
// Notes: interface selection for the low address bits
package pgdec_pkg;
  typedef enum logic {PGDEC_IF_PINS, PGDEC_IF_LATCH} pgdec_if_t;
endpackage : pgdec_pkg

// ==== hdl/pgdec_sync.sv ====
// Purpose: two-flop synchroniser for host pins
// Assumes: pins are asynchronous to mclk
// Notes: first stage is read only by the second
`timescale 1ns/100ps
module pgdec_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      meta_reg <= '0;
      q <= '0;
    end
    else
    begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : pgdec_sync

// ==== test/pgdec_host.sv ====
// Purpose: host processor model for the decoder's host side
// Assumes: one write per strobe
// Notes: strobe held long enough for the pin synchroniser
`timescale 1ns/100ps
module pgdec_host (
  input wire logic mclk,
  output logic [2:0] addr_pins,
  output logic [5:0] addr_latch,
  output logic if_is_latch,
  output logic wr_strobe,
  output logic [7:0] wr_data
);
  initial
  begin
    {if_is_latch, addr_pins, addr_latch, wr_strobe, wr_data} = '0;
  end
  task set_addr(input logic l, input logic [2:0] p, input logic [5:0] a);
    @(posedge mclk);
    if_is_latch <= l;
    addr_pins <= p;
    addr_latch <= a;
  endtask : set_addr
  // address stays until the next set_addr, well past the strobe
  task write(input logic [7:0] d);
    @(posedge mclk);
    wr_data <= d;
    @(posedge mclk);
    wr_strobe <= 1'b1;
    repeat (4) @(posedge mclk);
    wr_strobe <= 1'b0;
    // released data bus must not look like the last byte
    wr_data <= ~d;
    repeat (3) @(posedge mclk);
  endtask : write
endmodule : pgdec_host

// ==== test/paged_register_address_decode_bench.sv ====
// Purpose: self-checking bench of the paged address decoder
// Assumes: host model drives all host-side inputs
// Notes: six-cycle waits cover sync flops and output flop
`timescale 1ns/100ps
module paged_register_address_decode_bench;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] addr_pins, page_number;
  logic [5:0] addr_latch, reg_addr;
  logic if_is_latch, wr_strobe, page_sel_hit, use_page_flag;
  logic [7:0] wr_data, page_sel_rdata;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  pgdec_host i_host (.mclk(mclk), .addr_pins(addr_pins), .addr_latch(addr_latch), .if_is_latch(if_is_latch),
    .wr_strobe(wr_strobe), .wr_data(wr_data));
  pgdec_top i_dut (.mclk(mclk), .nrst(nrst), .addr_pins(addr_pins), .addr_latch(addr_latch),
    .if_is_latch(if_is_latch), .wr_strobe(wr_strobe), .wr_data(wr_data), .reg_addr(reg_addr),
    .page_sel_hit(page_sel_hit), .use_page_flag(use_page_flag), .page_number(page_number),
    .page_sel_rdata(page_sel_rdata));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task look(input logic [7:0] rd, input logic [5:0] ra, input logic hit);
    repeat (6) @(posedge mclk);
    #1;
    chk("rdata", page_sel_rdata, rd);
    chk("reg_addr", {2'h0, reg_addr}, {2'h0, ra});
    chk("hit", {7'h0, page_sel_hit}, {7'h0, hit});
    chk("flag", {7'h0, use_page_flag}, {7'h0, rd[7]});
    chk("page", {5'h0, page_number}, {5'h0, rd[2:0]});
  endtask : look
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  // ****************************************
  // hang guard, far above the run length
  // ****************************************
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  initial
  begin
    // two reset edges; sync stages clear directly, not by shifting
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    look(8'h80, 6'h00, 1'b1);
    i_host.write(8'hff);
    look(8'h87, 6'h38, 1'b1);
    i_host.set_addr(1'b0, 3'h5, 6'h00);
    look(8'h87, 6'h3d, 1'b0);
    i_host.set_addr(1'b1, 3'h0, 6'h2a);
    look(8'h87, 6'h3a, 1'b0);
    i_host.write(8'h03);
    look(8'h87, 6'h3a, 1'b0);
    i_host.set_addr(1'b1, 3'h0, 6'h28);
    i_host.write(8'h83);
    look(8'h83, 6'h18, 1'b1);
    i_host.set_addr(1'b0, 3'h1, 6'h00);
    i_host.write(8'h00);
    look(8'h83, 6'h19, 1'b0);
    i_host.set_addr(1'b0, 3'h0, 6'h00);
    i_host.write(8'h00);
    look(8'h00, 6'h00, 1'b1);
    i_host.set_addr(1'b0, 3'h5, 6'h2b);
    look(8'h00, 6'h2b, 1'b0);
    i_host.set_addr(1'b1, 3'h0, 6'h10);
    i_host.write(8'h82);
    look(8'h82, 6'h10, 1'b1);
    report_and_stop();
  end
endmodule : paged_register_address_decode_bench
